// ### counter_timer.sv
`default_nettype none
module counter_timer
  import ctr_pkg::*;
#(
  parameter int TWIDTH = TIMER_WIDTH,
  parameter int AWIDTH = ADDR_WIDTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire host_strobe_t strobe_i,
  input wire logic [SRC_COUNT-1:0] timer_src_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic timer_irq_enable_o,
  output logic [1:0] timer_src_select_o,
  output logic [TWIDTH-1:0] timer_count_o,
  output logic [AWIDTH-1:0] acq_address_counter_o,
  output logic mem_full_o
);
  localparam logic [STROBE_WIDTH-1:0] STROBE_IDLE = '1;
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = {STROBE_IDLE, {(SYNC_WIDTH-STROBE_WIDTH){1'b0}}};

  logic [SYNC_WIDTH-1:0] sync_level;
  logic [SYNC_WIDTH-1:0] sync_rise;
  logic [SYNC_WIDTH-1:0] sync_fall;
  host_strobe_t lvl;
  host_strobe_t fall;
  host_strobe_t rise;
  logic [SRC_COUNT-1:0] src_rise;
  logic [7:0] data_s;

  pin_sync #(
    .WIDTH(SYNC_WIDTH),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i({strobe_i, timer_src_i, data_i}),
    .level_o(sync_level),
    .rise_o(sync_rise),
    .fall_o(sync_fall)
  );

  assign lvl = host_strobe_t'(sync_level[SYNC_WIDTH-1 -: STROBE_WIDTH]);
  assign fall = host_strobe_t'(sync_fall[SYNC_WIDTH-1 -: STROBE_WIDTH]);
  assign rise = host_strobe_t'(sync_rise[SYNC_WIDTH-1 -: STROBE_WIDTH]);
  assign src_rise = sync_rise[8 +: SRC_COUNT];
  assign data_s = sync_level[7:0];

  // Control latch
  logic [2:0] ctrl_ff;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl_ff <= CTRL_RESET;
    else if (fall.ctrl_write_n)
      ctrl_ff <= data_s[2:0];
  end

  assign timer_irq_enable_o = ctrl_ff[CTRL_IRQ_EN_BIT];
  assign timer_src_select_o = {ctrl_ff[CTRL_SEL1_BIT], ctrl_ff[CTRL_SEL0_BIT]};

  // Host step pulse: raised by the strobe, dropped when the strobe returns high
  logic step_pulse_ff;
  logic step_pulse_prev_ff;
  logic host_inc;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      step_pulse_ff <= 1'b0;
    else if (lvl.timer_step_n)
      step_pulse_ff <= 1'b0;
    else if (fall.timer_step_n)
      step_pulse_ff <= 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      step_pulse_prev_ff <= 1'b0;
    else
      step_pulse_prev_ff <= step_pulse_ff;
  end

  assign host_inc = step_pulse_ff && !step_pulse_prev_ff;

  // Normal sources: select code 1..3 picks source 0..2, code 0 blocks all
  logic src_inc;

  always_comb
  begin
    unique case (timer_src_select_o)
      2'h0: src_inc = 1'b0;
      2'h1: src_inc = src_rise[0];
      2'h2: src_inc = src_rise[1];
      2'h3: src_inc = src_rise[2];
    endcase
  end

  logic timer_clear;
  logic timer_inc;
  logic [TWIDTH-1:0] timer_count;

  assign timer_clear = !lvl.timer_clear_enable_n && !lvl.timer_clear_strobe_n;
  assign timer_inc = host_inc || src_inc;

  // Wrap output left open: the timer raises no status on rollover
  step_counter #(
    .WIDTH(TWIDTH)
  ) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(timer_clear),
    .load_mask_i('0),
    .load_val_i('0),
    .inc_i(timer_inc),
    .count_o(timer_count),
    .wrap_o()
  );

  assign timer_count_o = timer_count;

  // Address counter
  logic [AWIDTH-1:0] addr_mask;
  logic [AWIDTH-1:0] addr_val;
  logic addr_load;
  logic addr_wrap;
  logic [AWIDTH-1:0] addr_count;

  always_comb
  begin
    addr_mask = '0;
    if (fall.addr_load_low_n)
      addr_mask = addr_mask | ADDR_LOW_MASK;
    if (fall.addr_load_high_n)
      addr_mask = addr_mask | ADDR_HIGH_MASK;
  end

  assign addr_val = {data_s[1:0], data_s};
  assign addr_load = |addr_mask;

  step_counter #(
    .WIDTH(AWIDTH)
  ) u_addr (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(1'b0),
    .load_mask_i(addr_mask),
    .load_val_i(addr_val),
    .inc_i(rise.addr_step_n),
    .count_o(addr_count),
    .wrap_o(addr_wrap)
  );

  assign acq_address_counter_o = addr_count;

  logic full_ff;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      full_ff <= 1'b0;
    else if (addr_wrap)
      full_ff <= 1'b1;
    else if (addr_load)
      full_ff <= 1'b0;
  end

  assign mem_full_o = full_ff;

  // Readback buffer; one select at a time is expected, priority runs timer low, timer high, address low, address high
  logic [7:0] rd_data_ff;
  logic rd_oe_ff;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_ff <= 8'h00;
      rd_oe_ff <= 1'b0;
    end
    else
    begin
      rd_oe_ff <= !(lvl.timer_read_low_n && lvl.timer_read_high_n &&
                    lvl.addr_read_low_n && lvl.addr_read_high_n);
      if (!lvl.timer_read_low_n)
        rd_data_ff <= timer_count[7:0];
      else if (!lvl.timer_read_high_n)
        rd_data_ff <= timer_count[15:8];
      else if (!lvl.addr_read_low_n)
        rd_data_ff <= addr_count[7:0];
      else if (!lvl.addr_read_high_n)
        rd_data_ff <= {full_ff, 5'h00, addr_count[9:8]};
      else
        rd_data_ff <= 8'h00;
    end
  end

  assign data_o = rd_data_ff;
  assign data_oe_o = rd_oe_ff;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  clear_zero_a: assert property (timer_clear |=> timer_count == 16'h0000)
    else $error("timer not zero after clear");
  step_once_a: assert property (host_inc && !timer_clear
    |=> timer_count == $past(timer_count) + 16'h0001)
    else $error("host step did not count once");
  pulse_drop_a: assert property (step_pulse_ff && lvl.timer_step_n |=> !step_pulse_ff)
    else $error("step pulse not dropped");
  ctrl_zero_a: assert property (fall.ctrl_write_n && data_s == 8'h00
    |=> !timer_irq_enable_o && timer_src_select_o == 2'h0)
    else $error("control latch not cleared");
  source_block_a: assert property (timer_src_select_o == 2'h0 && !host_inc
    && !timer_clear |=> $stable(timer_count))
    else $error("blocked source advanced timer");
  read_low_a: assert property (!lvl.timer_read_low_n
    |=> data_oe_o && data_o == $past(timer_count[7:0]))
    else $error("wrong timer low byte");
  read_high_a: assert property (lvl.timer_read_low_n && !lvl.timer_read_high_n
    |=> data_oe_o && data_o == $past(timer_count[15:8]))
    else $error("wrong timer high byte");
  timer_wrap_a: assert property (timer_count == 16'hFFFF && timer_inc
    && !timer_clear |=> timer_count == 16'h0000)
    else $error("timer did not wrap");
  full_set_a: assert property (addr_count == 10'h3FF && rise.addr_step_n
    && !addr_load |=> mem_full_o && addr_count == 10'h000)
    else $error("full not set on wrap");
  load_clear_a: assert property (addr_load |=> !mem_full_o)
    else $error("full not cleared on load");
  addr_step_a: assert property (rise.addr_step_n && !addr_load
    |=> addr_count == $past(addr_count) + 10'h001)
    else $error("address counter miscounted");

  // Timer stepping and holding, control latch holding
  pulse_rise_a: assert property (fall.timer_step_n |=> step_pulse_ff)
    else $error("step pulse not raised");
  step_idle_a: assert property (lvl.timer_step_n |=> !host_inc)
    else $error("host step counted while strobe high");
  timer_still_a: assert property (!timer_inc && !timer_clear
    |=> $stable(timer_count))
    else $error("timer moved without a step");
  src_count_a: assert property (src_inc && !timer_clear
    |=> timer_count == $past(timer_count) + 16'h0001)
    else $error("source edge did not count once");
  ctrl_hold_a: assert property (!fall.ctrl_write_n
    |=> $stable(timer_src_select_o) && $stable(timer_irq_enable_o))
    else $error("control latch changed without a write");

  // Address counter loading, holding and readback
  load_low_a: assert property (fall.addr_load_low_n && !fall.addr_load_high_n
    |=> addr_count[7:0] == $past(data_s) && addr_count[9:8] == $past(addr_count[9:8]))
    else $error("address low load wrong");
  load_high_a: assert property (fall.addr_load_high_n && !fall.addr_load_low_n
    |=> addr_count[9:8] == $past(data_s[1:0]) && addr_count[7:0] == $past(addr_count[7:0]))
    else $error("address high load wrong");
  addr_still_a: assert property (!rise.addr_step_n && !addr_load
    |=> $stable(addr_count))
    else $error("address moved without a step");
  full_hold_a: assert property (mem_full_o && !addr_load |=> mem_full_o)
    else $error("full flag not sticky");
  addr_low_rd_a: assert property (lvl.timer_read_low_n && lvl.timer_read_high_n
    && !lvl.addr_read_low_n |=> data_oe_o && data_o == $past(addr_count[7:0]))
    else $error("wrong address low byte");
  addr_high_rd_a: assert property (lvl.timer_read_low_n && lvl.timer_read_high_n
    && lvl.addr_read_low_n && !lvl.addr_read_high_n
    |=> data_oe_o && data_o == {$past(full_ff), 5'h00, $past(addr_count[9:8])})
    else $error("wrong address high byte");
  read_idle_a: assert property (lvl.timer_read_low_n && lvl.timer_read_high_n
    && lvl.addr_read_low_n && lvl.addr_read_high_n |=> !data_oe_o && data_o == 8'h00)
    else $error("bus not idle");


  timer_rollover_c: cover property (timer_count == 16'hFFFF && host_inc);
  addr_rollover_c: cover property (addr_wrap ##1 mem_full_o);
  read_pair_c: cover property (!lvl.timer_read_low_n ##[1:20] !lvl.timer_read_high_n);
  clear_c: cover property (timer_count != 16'h0000 && timer_clear);
  src_count_c: cover property (src_inc && timer_src_select_o == 2'h3);
endmodule
`default_nettype wire

// ### counter_timer_bench.sv
`default_nettype none
module counter_timer_bench
  import ctr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam host_strobe_t CLR_EN = 11'h400;
  localparam host_strobe_t CLR = 11'h200;
  localparam host_strobe_t STEP = 11'h100;
  localparam host_strobe_t RD_TL = 11'h080;
  localparam host_strobe_t RD_TH = 11'h040;
  localparam host_strobe_t RD_AL = 11'h020;
  localparam host_strobe_t RD_AH = 11'h010;
  localparam host_strobe_t LD_AL = 11'h008;
  localparam host_strobe_t LD_AH = 11'h004;
  localparam host_strobe_t ASTEP = 11'h002;
  localparam host_strobe_t WR_C = 11'h001;
  logic clk_i;
  logic rst_n_i;
  host_strobe_t strobe;
  logic [2:0] src;
  logic [7:0] hdata;
  logic [7:0] data_o;
  logic data_oe;
  logic irq_en;
  logic [1:0] sel;
  logic [15:0] tcount;
  logic [9:0] addr;
  logic full;
  logic [8:0] rd;
  int err_count;
  int compares;
  logic [15:0] n_edges [3] = '{16'h54AB, 16'h5555, 16'h0004};
  logic [15:0] t_exp [3] = '{16'h5555, 16'hAAAA, 16'hAAAE};

  counter_timer counter_timer_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .strobe_i(strobe),
    .timer_src_i(src), .data_i(hdata), .data_o(data_o), .data_oe_o(data_oe),
    .timer_irq_enable_o(irq_en), .timer_src_select_o(sel), .timer_count_o(tcount),
    .acq_address_counter_o(addr), .mem_full_o(full));
  host_bus_model host_bus_model_i (.clk_i(clk_i), .data_i(data_o), .data_oe_i(data_oe),
    .strobe_o(strobe), .data_o(hdata));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic op(input host_strobe_t m, input logic [7:0] wd, input int hold = 5);
    host_bus_model_i.cycle(m, wd, hold, rd);
  endtask

  // Low byte first, then high byte; bus released afterwards
  task automatic read_timer(input logic [15:0] exp);
    op(RD_TL, 8'h00);
    check("timer_low", 16'(rd), {8'h01, exp[7:0]});
    op(RD_TH, 8'h00);
    check("timer_high", 16'(rd), {8'h01, exp[15:8]});
    check("bus_idle", {7'h0, data_oe, data_o}, 16'h0000);
  endtask

  task automatic src_edges(input int idx, input logic [15:0] n);
    repeat (n)
    begin
      src[idx] <= 1'b1;
      @(posedge clk_i);
      src[idx] <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  initial
  begin
    repeat (102000) @(posedge clk_i);
    err_count++;
    end_sim();
  end

  initial
  begin
    rst_n_i = 1'b0;
    src = 3'h0;
    err_count = 0;
    compares = 0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    op(WR_C, 8'h07);
    check("ctrl_set", {13'h0, irq_en, sel}, 16'h0007);
    op(WR_C, 8'h00);
    check("ctrl_zero", {13'h0, irq_en, sel}, 16'h0000);
    op(STEP, 8'h00, 12);
    repeat (2) op(STEP, 8'h00, 3);
    check("long_step", tcount, 16'h0003);
    op(CLR, 8'h00);
    check("half_clear", tcount, 16'h0003);
    for (int i = 0; i < 3; i++)
      src_edges(i, 16'h0004);
    check("src_blocked", tcount, 16'h0003);
    op(CLR_EN | CLR, 8'h00);
    read_timer(16'h0000);
    repeat (16'h55) op(STEP, 8'h00, 3);
    read_timer(16'h0055);
    repeat (16'h55) op(STEP, 8'h00, 3);
    read_timer(16'h00AA);
    for (int k = 1; k <= 3; k++)
    begin
      op(WR_C, 8'(k << 1));
      for (int j = 0; j < 3; j++)
        if (j != k - 1)
          src_edges(j, 16'h0004);
      src_edges(k - 1, n_edges[k - 1]);
      op(WR_C, 8'h00);
      read_timer(t_exp[k - 1]);
    end
    for (int i = 0; i < 8; i++)
    begin
      op(LD_AL, 8'h80 >> i);
      op(RD_AL, 8'h00);
      check("addr_low", 16'(rd), {8'h01, 8'h80 >> i});
    end
    for (int i = 0; i < 2; i++)
    begin
      op(LD_AH, 8'(1 << i));
      op(RD_AH, 8'h00);
      check("addr_high", 16'(rd), {8'h01, 8'(1 << i)});
    end
    op(LD_AH, 8'h00);
    op(LD_AL, 8'h00);
    for (int j = 1; j < 1024; j++)
    begin
      op(ASTEP, 8'h00, 3);
      check("addr_count", {5'h0, full, addr}, 16'(j));
    end
    op(ASTEP, 8'h00, 3);
    op(RD_AH, 8'h00);
    check("addr_wrap", {5'h0, full, addr}, 16'h0400);
    check("full_read", 16'(rd), 16'h0180);
    op(LD_AH, 8'h03);
    op(LD_AL, 8'hFF);
    check("load_full", {5'h0, full, addr}, 16'h03FF);
    op(ASTEP, 8'h00, 3);
    check("max_wrap", {5'h0, full, addr}, 16'h0400);
    end_sim();
  end
endmodule
`default_nettype wire

// ### ctr_pkg.sv
`default_nettype none
package ctr_pkg;
  // Host-side port numbers of the two timer readback bytes
  localparam logic [7:0] TIMER_COUNT_LOW_PORT = 8'h05;
  localparam logic [7:0] TIMER_COUNT_HIGH_PORT = 8'h06;

  localparam int TIMER_WIDTH = 16;
  localparam int ADDR_WIDTH = 10;
  localparam int SRC_COUNT = 3;

  // Control latch field positions
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int CTRL_SEL0_BIT = 1;
  localparam int CTRL_SEL1_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Address readback high byte: full flag position
  localparam int ADDR_FULL_BIT = 7;
  localparam logic [ADDR_WIDTH-1:0] ADDR_LOW_MASK = 10'h0FF;
  localparam logic [ADDR_WIDTH-1:0] ADDR_HIGH_MASK = 10'h300;

  // Host strobes, all active low
  typedef struct packed {
    logic timer_clear_enable_n;
    logic timer_clear_strobe_n;
    logic timer_step_n;
    logic timer_read_low_n;
    logic timer_read_high_n;
    logic addr_read_low_n;
    logic addr_read_high_n;
    logic addr_load_low_n;
    logic addr_load_high_n;
    logic addr_step_n;
    logic ctrl_write_n;
  } host_strobe_t;

  localparam int STROBE_WIDTH = $bits(host_strobe_t);
  localparam int SYNC_WIDTH = STROBE_WIDTH + SRC_COUNT + 8;
endpackage
`default_nettype wire

// ### host_bus_model.sv
`default_nettype none
module host_bus_model
  import ctr_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  input wire logic data_oe_i,
  output var host_strobe_t strobe_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    strobe_o = '1;
    data_o = 8'h00;
  end

  // One strobe cycle: data set up 3 clocks early, strobe low for hold clocks,
  // readback taken in the middle of the last low cycle, then 4 idle clocks
  task automatic cycle(input host_strobe_t low, input logic [7:0] wd, input int hold,
                       output logic [8:0] rd);
    data_o <= wd;
    repeat (3) @(posedge clk_i);
    strobe_o <= ~low;
    repeat (hold - 1) @(posedge clk_i);
    // Settled readback, away from the edge that updates it
    @(negedge clk_i);
    rd = {data_oe_i, data_i};
    @(posedge clk_i);
    strobe_o <= '1;
    // Released bus shows the inverse of the last value
    data_o <= ~wd;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### pin_sync.sv
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;

  // Only sync_ff reads meta_ff
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
      prev_ff <= RESET_VAL;
    end
    else
    begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_o = sync_ff;
  assign rise_o = sync_ff & ~prev_ff;
  assign fall_o = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// ### step_counter.sv
`default_nettype none
module step_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic [WIDTH-1:0] load_mask_i,
  input wire logic [WIDTH-1:0] load_val_i,
  input wire logic inc_i,
  output logic [WIDTH-1:0] count_o,
  output logic wrap_o
);
  logic [WIDTH-1:0] count_ff;
  logic loading;

  assign loading = |load_mask_i;
  // Wrap is the step that takes the all-ones value back to zero
  assign wrap_o = inc_i && !clear_i && !loading && (&count_ff);

  // Clear beats load, load beats step
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_ff <= '0;
    else if (clear_i)
      count_ff <= '0;
    else if (loading)
      count_ff <= (count_ff & ~load_mask_i) | (load_val_i & load_mask_i);
    else if (inc_i)
      count_ff <= count_ff + 1'b1;
  end

  assign count_o = count_ff;
endmodule
`default_nettype wire
